// *** hdl/rlas_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Spacing fault held while marker gap wrong
// - Repeated fault after four successive marker errors
// - Malformed marker pulses one cycle per word
// - Misalign needs all lanes seen, then bad
// - Misalign pulse one metaframe after offending marker
// - No misalign pulse before good markers seen
// - Alignment fault on deskew error or loss
// - Per lane parity mismatch pulses one cycle
// - Aligned output only while all lanes deskewed
// - Not aligned means local fault present
// - Excessive error rate flag at or over limit
// - Synced needs header lock plus marker seen
module rlas_monitor
   import rlas_pkg::*;
#(
   parameter int unsigned LANES     = LANES_DEF,
   parameter int unsigned BER_CYC   = BER_WINDOW_CYC,
   parameter int unsigned BER_LIMIT = BER_LIMIT_DEF
) (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_resetn,
   input  wire logic                 i_clk_en,
   input  wire logic [SPACING_W-1:0] i_marker_spacing_words_less_one,
   input  wire logic [LANES-1:0]     i_hdr_locked,
   input  wire logic [LANES-1:0]     i_hdr_invalid,
   input  wire logic [LANES-1:0]     i_word_valid,
   input  wire logic [LANES-1:0]     i_marker_seen,
   input  wire logic [LANES-1:0]     i_marker_wellformed,
   input  wire logic [LANES-1:0]     i_marker_lane_match,
   input  wire logic [LANES-1:0]     i_bip_match,
   output logic      [LANES-1:0]     o_lane_synced,
   output logic      [LANES-1:0]     o_marker_spacing_fault,
   output logic      [LANES-1:0]     o_marker_repeated_fault,
   output logic      [LANES-1:0]     o_marker_word_malformed,
   output logic      [LANES-1:0]     o_parity_error,
   output logic                      o_misaligned,
   output logic                      o_alignment_fault,
   output logic                      o_all_lanes_aligned,
   output logic                      o_local_fault,
   output logic                      o_error_rate_excessive
);
   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (LANES != LANES_DEF || BER_CYC < 2 || BER_CYC >= (1 << 20) || BER_LIMIT >= (1 << BER_W)) begin : g_bad
      $error("rlas_monitor: unsupported parameter values");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [LANES-1:0]                synced;
      logic [LANES-1:0]                good_seen;
      logic                            all_seen;
      logic [LANES-1:0][SPACING_W-1:0] gap;
      logic [LANES-1:0]                spc;
      logic [LANES-1:0][RPT_W-1:0]     rpt_cnt;
      logic [LANES-1:0]                rpt;
      logic [LANES-1:0]                malf;
      logic [LANES-1:0]                bip;
      logic [LANES-1:0]                mis_arm;
      logic [LANES-1:0][SPACING_W-1:0] mis_cnt;
      logic                            mis;
      logic                            aligned;
      logic                            align_err;
      logic [19:0]                     ber_win;
      logic [BER_W-1:0]                ber_bad;
      logic                            hi_ber;
   } rlas_state_t;

   rlas_state_t st_r;
   rlas_state_t st_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic             mark_err;
      logic             wrong_lane;
      logic             any_wrong;
      logic [BER_W-1:0] bad_add;
      mark_err   = 1'h0;
      wrong_lane = 1'h0;
      any_wrong  = 1'h0;
      bad_add    = '0;
      st_nxt     = st_r;
      st_nxt.mis = 1'h0;
      for (int l = 0; l < LANES; l++) begin
         st_nxt.malf[l] = i_hdr_locked[l] && i_marker_seen[l] && !i_marker_wellformed[l];
         st_nxt.bip[l]  = st_r.synced[l] && i_marker_seen[l] && i_marker_wellformed[l]
                          && !i_bip_match[l];
         mark_err       = 1'h0;
         wrong_lane     = 1'h0;
         if (!i_hdr_locked[l]) begin
            st_nxt.synced[l]    = 1'h0;
            st_nxt.good_seen[l] = 1'h0;
            st_nxt.spc[l]       = 1'h0;
            st_nxt.rpt_cnt[l]   = '0;
            st_nxt.gap[l]       = '0;
            st_nxt.mis_arm[l]   = 1'h0;
         end else if (i_word_valid[l]) begin
            if (i_marker_seen[l] && i_marker_wellformed[l]) begin
               st_nxt.synced[l] = 1'h1;
               st_nxt.gap[l]    = '0;
               if (st_r.synced[l]) begin
                  st_nxt.spc[l] = (st_r.gap[l] != i_marker_spacing_words_less_one);
                  mark_err      = st_nxt.spc[l] || !i_marker_lane_match[l];
               end
               wrong_lane = !i_marker_lane_match[l];
               if (!wrong_lane && !st_nxt.spc[l]) begin
                  st_nxt.good_seen[l] = 1'h1;
               end
            end else if (i_marker_seen[l]) begin
               st_nxt.gap[l] = '0;
               mark_err      = st_r.synced[l];
            end else begin
               if (st_r.gap[l] != '1) begin
                  st_nxt.gap[l] = st_r.gap[l] + 1'h1;
               end
               if (st_r.synced[l] && st_r.gap[l] >= i_marker_spacing_words_less_one) begin
                  st_nxt.spc[l] = 1'h1;
                  mark_err      = (st_r.gap[l] == i_marker_spacing_words_less_one);
               end
            end
            if (st_r.synced[l] && i_marker_seen[l]) begin
               if (mark_err) begin
                  if (st_r.rpt_cnt[l] != RPT_W'(RPT_LIMIT)) begin
                     st_nxt.rpt_cnt[l] = st_r.rpt_cnt[l] + 1'h1;
                  end
               end else begin
                  st_nxt.rpt_cnt[l] = '0;
               end
            end else if (mark_err) begin
               st_nxt.rpt_cnt[l] = (st_r.rpt_cnt[l] != RPT_W'(RPT_LIMIT)) ? st_r.rpt_cnt[l] + 1'h1 : st_r.rpt_cnt[l];
            end
            if (st_r.mis_arm[l]) begin
               if (st_r.mis_cnt[l] == i_marker_spacing_words_less_one) begin
                  st_nxt.mis_arm[l] = 1'h0;
                  st_nxt.mis        = 1'h1;
               end else begin
                  st_nxt.mis_cnt[l] = st_r.mis_cnt[l] + 1'h1;
               end
            end
            if (st_r.all_seen && st_r.synced[l] && i_marker_seen[l] && i_marker_wellformed[l]
                && wrong_lane) begin
               st_nxt.mis_arm[l] = 1'h1;
               st_nxt.mis_cnt[l] = '0;
               any_wrong         = 1'h1;
            end
         end
         st_nxt.rpt[l] = (st_nxt.rpt_cnt[l] == RPT_W'(RPT_LIMIT));
         bad_add       = bad_add + BER_W'(i_hdr_invalid[l]);
      end
      st_nxt.all_seen = st_r.all_seen ? (&i_hdr_locked) : (&st_nxt.good_seen);
      st_nxt.aligned  = (&st_nxt.synced) && !(|st_nxt.rpt) && st_nxt.all_seen;
      if ((st_r.aligned && !st_nxt.aligned) || any_wrong) begin
         st_nxt.align_err = 1'h1;
      end else if (st_nxt.aligned) begin
         st_nxt.align_err = 1'h0;
      end
      if (st_r.ber_win == 20'(BER_CYC - 1)) begin
         st_nxt.hi_ber  = (st_r.ber_bad >= BER_W'(BER_LIMIT));
         st_nxt.ber_win = '0;
         st_nxt.ber_bad = '0;
      end else begin
         st_nxt.ber_win = st_r.ber_win + 1'h1;
         if (st_r.ber_bad <= '1 - bad_add) begin
            st_nxt.ber_bad = st_r.ber_bad + bad_add;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_lane_synced           = st_r.synced;
   assign o_marker_spacing_fault  = st_r.spc;
   assign o_marker_repeated_fault = st_r.rpt;
   assign o_marker_word_malformed = st_r.malf;
   assign o_parity_error          = st_r.bip;
   assign o_misaligned            = st_r.mis;
   assign o_alignment_fault       = st_r.align_err;
   assign o_all_lanes_aligned     = st_r.aligned;
   assign o_local_fault           = !st_r.aligned;
   assign o_error_rate_excessive  = st_r.hi_ber;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   for (genvar g = 0; g < LANES; g++) begin : g_chk
      a_malformed_pulse: assert property (i_clk_en && i_hdr_locked[g] && i_marker_seen[g]
                                          && !i_marker_wellformed[g] |=> o_marker_word_malformed[g])
         else $error("malformed marker not flagged");
      a_parity_pulse: assert property (i_clk_en && st_r.synced[g] && i_marker_seen[g]
                                       && i_marker_wellformed[g] && !i_bip_match[g] |=> o_parity_error[g])
         else $error("parity mismatch not flagged");
      a_spacing_set: assert property (i_clk_en && i_hdr_locked[g] && i_word_valid[g] && st_r.synced[g]
                                      && i_marker_seen[g] && i_marker_wellformed[g]
                                      && st_r.gap[g] != i_marker_spacing_words_less_one |=> o_marker_spacing_fault[g])
         else $error("spacing fault not raised");
      a_repeat_count: assert property ($rose(o_marker_repeated_fault[g]) |->
                                       $past(st_r.rpt_cnt[g]) == RPT_W'(RPT_LIMIT - 1))
         else $error("repeated fault not after four errors");
      a_synced_lock: assert property (o_lane_synced[g] |-> $past(i_hdr_locked[g]))
         else $error("lane synced without header lock");
   end

   a_misalign_gate: assert property (o_misaligned |-> $past(st_r.all_seen))
      else $error("misalign before all lanes seen");
   a_misalign_never: assert property (!(|st_r.good_seen) && !st_r.all_seen |=> !o_misaligned)
      else $error("misalign with no good markers");
   a_aligned_lanes: assert property (o_all_lanes_aligned |-> (&o_lane_synced) && !(|o_marker_repeated_fault))
      else $error("aligned with a lane not ready");
   a_local_fault: assert property (o_local_fault == !o_all_lanes_aligned)
      else $error("local fault disagrees with aligned");
   a_align_loss: assert property ($fell(o_all_lanes_aligned) |-> o_alignment_fault)
      else $error("alignment loss not reported");
   a_ber_window: assert property (i_clk_en && st_r.ber_win == 20'(BER_CYC - 1)
                                  && st_r.ber_bad >= BER_W'(BER_LIMIT) |=> o_error_rate_excessive)
      else $error("error rate flag missed");

   c_aligned: cover property ($rose(o_all_lanes_aligned));
   c_misalign: cover property (o_misaligned);
   c_repeat: cover property ($rose(|o_marker_repeated_fault));
   c_hi_ber: cover property ($rose(o_error_rate_excessive));
endmodule
`default_nettype wire

// *** hdl/rlas_pkg.sv ***
package rlas_pkg;
   // ----------------------------------------
   // Lane and counter geometry
   // ----------------------------------------
   localparam int unsigned LANES_DEF      = 4;
   localparam int unsigned SPACING_W      = 16;
   localparam int unsigned RPT_LIMIT      = 4;
   localparam int unsigned RPT_W          = 3;
   // ----------------------------------------
   // Error rate window
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned BER_WINDOW_NS  = 125000;
   localparam int unsigned BER_WINDOW_CYC = BER_WINDOW_NS / CLK_PERIOD_NS;
   localparam int unsigned BER_LIMIT_DEF  = 97;
   localparam int unsigned BER_W          = 12;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic        RST_BIT        = 1'h0;
endpackage

// *** verif/rlas_stat_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module rlas_stat_sink
   import rlas_pkg::*;
(
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_resetn,
   input  wire logic [LANES_DEF-1:0] i_malformed,
   input  wire logic [LANES_DEF-1:0] i_parity,
   input  wire logic                 i_aligned,
   input  wire logic                 i_local_fault,
   output logic      [7:0]           o_pulse_cnt,
   output logic      [7:0]           o_fault_bad
);
   // ----------------------------------------
   // Pulse counting and fault tracking
   // ----------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pulse_cnt <= 8'h00;
         o_fault_bad <= 8'h00;
      end else begin
         o_pulse_cnt <= o_pulse_cnt + 8'($countones(i_malformed)) + 8'($countones(i_parity));
         if (i_local_fault !== !i_aligned) begin
            o_fault_bad <= o_fault_bad + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/tb_rx_lane_alignment_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_rx_lane_alignment_status;
   import rlas_pkg::*;
   logic       i_sys_clk, i_resetn;
   logic [3:0] lock, inv, mk, wf, bip, lm, wv, synced, spc, rpt, malf, par;
   logic       ce, misal, alf, aligned, lfault, ber;
   logic [7:0] pulse_cnt, fault_bad;
   int         n_errors, total_checks;

   rlas_monitor #(.LANES(4), .BER_CYC(16), .BER_LIMIT(3)) rlas_monitor_i (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(ce),
      .i_marker_spacing_words_less_one(16'h0003), .i_hdr_locked(lock),
      .i_hdr_invalid(inv), .i_word_valid(wv), .i_marker_seen(mk),
      .i_marker_wellformed(wf), .i_marker_lane_match(lm), .i_bip_match(bip),
      .o_lane_synced(synced), .o_marker_spacing_fault(spc),
      .o_marker_repeated_fault(rpt), .o_marker_word_malformed(malf),
      .o_parity_error(par), .o_misaligned(misal), .o_alignment_fault(alf),
      .o_all_lanes_aligned(aligned), .o_local_fault(lfault),
      .o_error_rate_excessive(ber));

   rlas_stat_sink rlas_stat_sink_i (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_malformed(malf),
      .i_parity(par), .i_aligned(aligned), .i_local_fault(lfault),
      .o_pulse_cnt(pulse_cnt), .o_fault_bad(fault_bad));

   // ----------------------------------------
   // Clock, checks and closing
   // ----------------------------------------
   initial begin
      i_sys_clk = 1'h0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
      end
   endtask

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Drives one word; outputs then show the previous word
   task automatic drv(input logic [3:0] m, input logic [3:0] w, input logic [3:0] b,
                      input logic [3:0] l = 4'hF, input logic [3:0] v = 4'hF, input logic c = 1'h1);
      @(posedge i_sys_clk);
      mk <= m;
      wf <= w;
      bip <= b;
      lm <= l;
      wv <= v;
      ce <= c;
      #1;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_sync_pulses;
      drv(4'hF, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      chk(synced, 4'hF);
      chk(aligned, 1'h1);
      chk(lfault, 1'h0);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'hF, 4'hD, 4'hB);
      drv(4'h0, 4'hF, 4'hF);
      chk(malf, 4'h2);
      chk(par, 4'h4);
      drv(4'h0, 4'hF, 4'hF);
      chk(malf, 4'h0);
      chk(par, 4'h0);
   endtask

   task automatic t_spacing;
      repeat (4) begin
         drv(4'h1, 4'hF, 4'hF);
         drv(4'h0, 4'hF, 4'hF);
      end
      chk(spc[0], 1'h1);
      chk(rpt[0], 1'h1);
      chk(alf, 1'h1);
      chk(aligned, 1'h0);
      chk(lfault, 1'h1);
      chk(pulse_cnt, 8'h02);
      chk(fault_bad, 8'h00);
   endtask

   task automatic t_error_rate;
      @(posedge i_sys_clk);
      inv <= 4'hF;
      repeat (40) @(posedge i_sys_clk);
      #1;
      chk(ber, 1'h1);
      @(posedge i_sys_clk);
      inv <= 4'h0;
      repeat (40) @(posedge i_sys_clk);
      #1;
      chk(ber, 1'h0);
   endtask

   task automatic t_reset_mid;
      @(posedge i_sys_clk);
      i_resetn <= 1'h0;
      #1;
      chk({synced, spc, rpt, malf}, 16'h0000);
      chk({par, misal, alf, aligned, ber}, 8'h00);
      chk(lfault, 1'h1);
      @(posedge i_sys_clk);
      i_resetn <= 1'h1;
      mk <= 4'hF;
      lm <= 4'hB;
      #1;
      chk({synced, spc, rpt, malf}, 16'h0000);
      chk(lfault, 1'h1);
   endtask

   // Lane 2 first names the wrong lane, then is seen correctly
   task automatic t_misalign;
      drv(4'h0, 4'hF, 4'hF);
      chk(synced, 4'hF);
      chk(aligned, 1'h0);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'hF, 4'hF, 4'hF, 4'hB);
      repeat (3) drv(4'h0, 4'hF, 4'hF);
      drv(4'hF, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      chk(misal, 1'h0);
      chk(aligned, 1'h1);
      chk(lfault, 1'h0);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'hF, 4'hF, 4'hF, 4'hB);
      drv(4'h0, 4'hF, 4'hF);
      chk(alf, 1'h1);
      chk(misal, 1'h0);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'hF, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      chk(misal, 1'h1);
      drv(4'h0, 4'hF, 4'hF);
      chk(misal, 1'h0);
      drv(4'h1, 4'hE, 4'hF, 4'hF, 4'hF, 1'h0);
      drv(4'h0, 4'hF, 4'hF, 4'hF, 4'hE);
      chk(malf, 4'h0);
      drv(4'hE, 4'hF, 4'hF, 4'hF, 4'hE);
      drv(4'h0, 4'hF, 4'hF);
      drv(4'h1, 4'hF, 4'hF);
      drv(4'h0, 4'hF, 4'hF);
      chk(spc, 4'h0);
      chk(pulse_cnt, 8'h00);
      chk(fault_bad, 8'h00);
   endtask

   initial begin
      #(40 * 1000);
      n_errors++;
      report_and_stop;
   end

   initial begin
      {i_resetn, lock, inv, mk, wf, bip} = '0;
      {lm, wv, ce} = 9'h1FF;
      repeat (3) @(posedge i_sys_clk);
      i_resetn <= 1'h1;
      lock <= 4'hF;
      t_sync_pulses;
      t_spacing;
      t_error_rate;
      t_reset_mid;
      t_misalign;
      report_and_stop;
   end
endmodule
`default_nettype wire
